// File: shared/estc_regs.vh
// constants for the exposure start trigger controller
`ifndef ESTC_REGS_VH
`define ESTC_REGS_VH
// ----------------------------------------
// trigger source encodings
// ----------------------------------------
`define ESTC_SRC_SOFTWARE 3'h0
`define ESTC_SRC_USER_OUT 3'h1
`define ESTC_SRC_LINK 3'h2
`define ESTC_SRC_TIMER 3'h3
`define ESTC_SRC_LINE 3'h4
// ----------------------------------------
// edge select and exposure modes
// ----------------------------------------
`define ESTC_EDGE_RISING 1'b1
`define ESTC_EXP_TIMED 1'b0
`define ESTC_EXP_PULSE 1'b1
// ----------------------------------------
// counter widths and reset values
// ----------------------------------------
`define ESTC_CNT_W 32
`define ESTC_CNT_ZERO 32'h00000000
`define ESTC_CNT_ONE 32'h00000001
`endif

// File: hw/estc_edge_detect.v
// synchroniser and edge detector for one trigger input
`timescale 1ns/1ps
module estc_edge_detect #(
	parameter SYNC = 1
) (
	input wire clk,
	input wire rst_n,
	input wire sig_in,
	input wire rising_sel,
	output wire level,
	output wire edge_pulse
);
	reg s1_r;
	reg s2_r;
	reg s3_r;
	wire lvl;
	// two flops for pins; same-domain inputs bypass them
	always @(posedge clk) begin
		if (!rst_n) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end else begin
			s1_r <= sig_in;
			s2_r <= s1_r;
			s3_r <= lvl;
		end
	end
	assign lvl = SYNC ? s2_r : sig_in;
	assign level = lvl;
	// one cycle per qualifying transition
	assign edge_pulse = rising_sel ? (lvl & ~s3_r) : (~lvl & s3_r);
endmodule

// File: hw/estc_trigger_ctrl.v
// exposure start trigger controller
`timescale 1ns/1ps
`include "estc_regs.vh"
module estc_trigger_ctrl #(
	parameter CW = `ESTC_CNT_W
) (
	input wire clk,
	input wire rst_n,
	input wire acq_start,
	input wire acq_stop,
	input wire trigger_mode_on,
	input wire [2:0] trigger_source,
	input wire edge_select,
	input wire exposure_mode,
	input wire timer_edge_activation,
	input wire [CW-1:0] exposure_cycles,
	input wire [CW-1:0] free_run_period,
	input wire [CW-1:0] min_frame_period,
	input wire [CW-1:0] timer_duration_cycles,
	input wire [CW-1:0] readout_cycles,
	input wire software_trigger,
	input wire user_output_source,
	input wire link_trigger_source,
	input wire timer_active_source,
	input wire external_line_source,
	output wire waiting_for_trigger,
	output reg exposure_active,
	output reg frame_start,
	output reg acquiring,
	output reg [CW-1:0] frame_count
);
	// ----------------------------------------
	// states
	// ----------------------------------------
	localparam ST_IDLE = 2'b00;
	localparam ST_WAIT = 2'b01;
	localparam ST_EXPOSE = 2'b10;
	localparam ST_READ = 2'b11;

	reg [1:0] state_r;
	reg [1:0] state_nxt;
	reg [CW-1:0] exp_cnt_r;
	reg [CW-1:0] rd_cnt_r;
	reg [CW-1:0] fr_cnt_r;
	reg pulse_mode_r;
	reg [2:0] src_r;
	reg stop_pend_r;
	reg [CW-1:0] exp_len;
	wire lvl_user;
	wire lvl_link;
	wire lvl_timer;
	wire lvl_line;
	wire e_user;
	wire e_link;
	wire e_timer;
	wire e_line;
	reg sel_edge;
	reg sel_level;
	reg use_pulse;
	wire [CW-1:0] fr_period;
	wire fr_fire;
	wire trig;
	wire accept;
	wire exp_done;
	wire rd_done;

	// ----------------------------------------
	// trigger inputs
	// ----------------------------------------
	// pins are synchronised; the user and timer bits are internal logic
	estc_edge_detect #(.SYNC(0)) u_user (
		.clk(clk), .rst_n(rst_n), .sig_in(user_output_source),
		.rising_sel(edge_select), .level(lvl_user), .edge_pulse(e_user)
	);
	estc_edge_detect #(.SYNC(1)) u_link (
		.clk(clk), .rst_n(rst_n), .sig_in(link_trigger_source),
		.rising_sel(edge_select), .level(lvl_link), .edge_pulse(e_link)
	);
	estc_edge_detect #(.SYNC(0)) u_timer (
		.clk(clk), .rst_n(rst_n), .sig_in(timer_active_source),
		.rising_sel(edge_select), .level(lvl_timer), .edge_pulse(e_timer)
	);
	estc_edge_detect #(.SYNC(1)) u_line (
		.clk(clk), .rst_n(rst_n), .sig_in(external_line_source),
		.rising_sel(edge_select), .level(lvl_line), .edge_pulse(e_line)
	);

	// source mux: the edge starts a frame, the level may end it
	always @* begin
		sel_edge = 1'b0;
		sel_level = 1'b0;
		case (trigger_source)
			`ESTC_SRC_SOFTWARE: begin
				sel_edge = software_trigger;
			end
			`ESTC_SRC_USER_OUT: begin
				sel_edge = e_user;
				sel_level = lvl_user;
			end
			`ESTC_SRC_LINK: begin
				sel_edge = e_link;
				sel_level = lvl_link;
			end
			`ESTC_SRC_TIMER: begin
				sel_edge = e_timer;
				sel_level = lvl_timer;
			end
			`ESTC_SRC_LINE: begin
				sel_edge = e_line;
				sel_level = lvl_line;
			end
			default: begin
				sel_edge = 1'b0;
				sel_level = 1'b0;
			end
		endcase
	end

	// ----------------------------------------
	// free-run generator
	// ----------------------------------------
	// slower of configured and minimum period wins
	assign fr_period = (free_run_period < min_frame_period) ?
		min_frame_period : free_run_period;
	assign fr_fire = (fr_cnt_r >= fr_period - `ESTC_CNT_ONE);
	always @(posedge clk) begin
		if (!rst_n || state_r == ST_IDLE || trigger_mode_on) begin
			fr_cnt_r <= `ESTC_CNT_ZERO;
		end else if (fr_fire) begin
			fr_cnt_r <= `ESTC_CNT_ZERO;
		end else begin
			fr_cnt_r <= fr_cnt_r + `ESTC_CNT_ONE;
		end
	end

	// internal trigger when off, selected source when on
	assign trig = trigger_mode_on ? sel_edge : fr_fire;
	// a stop in the same cycle wins, so no start pulse without an exposure
	assign accept = (state_r == ST_WAIT) && trig && !stop_pend_r &&
		!acq_stop;
	assign waiting_for_trigger = (state_r == ST_WAIT);

	// exposure length selection per mode and source
	always @* begin
		use_pulse = 1'b0;
		exp_len = exposure_cycles;
		if (trigger_mode_on && trigger_source != `ESTC_SRC_SOFTWARE &&
			exposure_mode == `ESTC_EXP_PULSE) begin
			if (trigger_source == `ESTC_SRC_TIMER && timer_edge_activation) begin
				exp_len = timer_duration_cycles;
			end else begin
				use_pulse = 1'b1;
			end
		end
	end

	// pulse width ends when the level returns to inactive
	assign exp_done = pulse_mode_r ?
		(sel_level != edge_select || src_r != trigger_source) :
		(exp_cnt_r <= `ESTC_CNT_ONE);
	assign rd_done = (rd_cnt_r <= `ESTC_CNT_ONE);

	// ----------------------------------------
	// acquisition state machine
	// ----------------------------------------
	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (acq_start) state_nxt = ST_WAIT;
			end
			ST_WAIT: begin
				if (acq_stop || stop_pend_r) state_nxt = ST_IDLE;
				else if (accept) state_nxt = ST_EXPOSE;
			end
			ST_EXPOSE: begin
				if (exp_done) state_nxt = ST_READ;
			end
			ST_READ: begin
				// readout must finish before next frame; stop waits for it
				if (rd_done) state_nxt = (stop_pend_r || acq_stop) ? ST_IDLE : ST_WAIT;
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	always @(posedge clk) begin
		if (!rst_n) begin
			state_r <= ST_IDLE;
			exp_cnt_r <= `ESTC_CNT_ZERO;
			rd_cnt_r <= `ESTC_CNT_ZERO;
			pulse_mode_r <= 1'b0;
			src_r <= `ESTC_SRC_SOFTWARE;
			stop_pend_r <= 1'b0;
			exposure_active <= 1'b0;
			frame_start <= 1'b0;
			acquiring <= 1'b0;
			frame_count <= `ESTC_CNT_ZERO;
		end else begin
			state_r <= state_nxt;
			frame_start <= accept;
			exposure_active <= (state_nxt == ST_EXPOSE);
			acquiring <= (state_nxt != ST_IDLE);
			// stop is held off while a frame is in flight
			if (state_nxt == ST_IDLE) begin
				stop_pend_r <= 1'b0;
			end else if (acq_stop && state_r != ST_IDLE) begin
				stop_pend_r <= 1'b1;
			end
			if (accept) begin
				exp_cnt_r <= exp_len;
				pulse_mode_r <= use_pulse;
				src_r <= trigger_source;
				frame_count <= frame_count + `ESTC_CNT_ONE;
			end else if (state_r == ST_EXPOSE && exp_cnt_r != `ESTC_CNT_ZERO) begin
				exp_cnt_r <= exp_cnt_r - `ESTC_CNT_ONE;
			end
			if (state_r == ST_EXPOSE) begin
				rd_cnt_r <= readout_cycles;
			end else if (state_r == ST_READ && rd_cnt_r != `ESTC_CNT_ZERO) begin
				rd_cnt_r <= rd_cnt_r - `ESTC_CNT_ONE;
			end
		end
	end
endmodule

// File: verif/estc_trigger_ctrl_sva.sv
// concurrent checks on the exposure start trigger controller ports
`timescale 1ns/1ps
`include "estc_regs.vh"
module estc_sva #(parameter CW = 32) (
	input wire clk,
	input wire rst_n,
	input wire acq_stop,
	input wire trigger_mode_on,
	input wire [2:0] trigger_source,
	input wire exposure_mode,
	input wire [CW-1:0] exposure_cycles,
	input wire waiting_for_trigger,
	input wire exposure_active,
	input wire frame_start,
	input wire acquiring,
	input wire [CW-1:0] frame_count
);
	// ----
	// properties
	// ----
	reg [CW-1:0] len_r;
	wire timed = !trigger_mode_on || trigger_source == `ESTC_SRC_SOFTWARE || !exposure_mode;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// exposure length so far; pulse-width frames are judged by the bench instead
	always @(posedge clk) len_r <= exposure_active ? len_r + 1'b1 : {CW{1'b0}};
	a_start_pulse: assert property (frame_start |=> !frame_start)
		else $error("frame start too long");
	a_rise_start: assert property ($rose(exposure_active) |-> frame_start)
		else $error("exposure without start");
	a_accept_wait: assert property (frame_start |-> $past(waiting_for_trigger))
		else $error("start outside wait");
	a_exp_busy: assert property (exposure_active |-> !waiting_for_trigger)
		else $error("waiting in exposure");
	a_idle_quiet: assert property (!acquiring |-> !exposure_active)
		else $error("exposure while idle");
	a_count_step: assert property ($past(rst_n) && $changed(frame_count) |->
		frame_start && frame_count == $past(frame_count) + 1) else $error("count step");
	a_exp_len: assert property ($past(rst_n) && $fell(exposure_active) && timed |->
		len_r == exposure_cycles) else $error("exposure length");
	a_stop_defer: assert property (acq_stop && exposure_active |=> acquiring)
		else $error("stop cut a frame");
	c_free: cover property (frame_start && !trigger_mode_on);
	c_link: cover property (frame_start && trigger_source == `ESTC_SRC_LINK);
	c_stop: cover property ($fell(acquiring));
endmodule
bind estc_trigger_ctrl estc_sva #(.CW(CW)) u_sva (.clk, .rst_n, .acq_stop, .trigger_mode_on,
	.trigger_source, .exposure_mode, .exposure_cycles, .waiting_for_trigger, .exposure_active,
	.frame_start, .acquiring, .frame_count);

// File: verif/estc_src_model.sv
// behavioural far-side trigger sources: link and external line
`timescale 1ns/1ps
module estc_src_model (
	output reg link_o,
	output reg line_o
);
	// ----
	// pulse generator
	// ----
	initial {link_o, line_o} = 2'b00;
	// edges land 3 ns off the bench grid so the synchronisers see real skew
	task pulse(input reg lnk, input reg idl, input integer w);
		begin
			#3 drv(lnk, idl);
			#100 drv(lnk, !idl);
			#(w) drv(lnk, idl);
			#300; // idle gap keeps triggers under the maximum rate
		end
	endtask
	task drv(input reg lnk, input reg v);
		if (lnk) link_o = v;
		else line_o = v;
	endtask
endmodule

// File: verif/tb_estc_trigger_ctrl.sv
// self-checking bench for the exposure start trigger controller
`timescale 1ns/1ps
`include "estc_regs.vh"
module tb_estc_trigger_ctrl;
	reg clk = 0, rst_n = 0, acq_start = 0, acq_stop = 0, trigger_mode_on = 0, edge_select = 1;
	reg exposure_mode = 0, timer_edge_activation = 0, software_trigger = 0;
	reg user_output_source = 0, timer_active_source = 0;
	reg [2:0] trigger_source = 3'h0;
	reg [31:0] exposure_cycles = 32'h4, free_run_period = 32'h14, min_frame_period = 32'hA;
	reg [31:0] timer_duration_cycles = 32'h6, readout_cycles = 32'h4;
	wire link_trigger_source, external_line_source, waiting_for_trigger, exposure_active;
	wire frame_start, acquiring;
	wire [31:0] frame_count;
	integer n_mismatch = 0, checks_done = 0, fc = 0, a, b;
	always #5 clk = ~clk;
	estc_trigger_ctrl dut (.clk, .rst_n, .acq_start, .acq_stop, .trigger_mode_on, .trigger_source,
		.edge_select, .exposure_mode, .timer_edge_activation, .exposure_cycles, .free_run_period,
		.min_frame_period, .timer_duration_cycles, .readout_cycles, .software_trigger,
		.user_output_source, .link_trigger_source, .timer_active_source, .external_line_source,
		.waiting_for_trigger, .exposure_active, .frame_start, .acquiring, .frame_count);
	estc_src_model src (.link_o(link_trigger_source), .line_o(external_line_source));
	// ----
	// helpers
	// ----
	task chk(input logic [31:0] s, e, input string nm);
		begin
			checks_done++;
			if (s !== e) begin
				n_mismatch++;
				$display("Error %s expected %0h seen %0h", nm, e, s);
			end
		end
	endtask
	task cyc(input integer k);
		repeat (k) @(negedge clk);
	endtask
	// cycles spent with exposure at level v, bounded so a stuck design still ends
	task cnt(input reg v, output integer n);
		for (n = 0; n < 500 && exposure_active === v; n++) @(negedge clk);
	endtask
	task cmd(input reg st);
		begin
			cyc(1);
			{acq_stop, acq_start} = st ? 2'b10 : 2'b01;
			cyc(1);
			{acq_stop, acq_start} = 2'b00;
			while (st && acquiring !== 1'b0) cyc(1);
		end
	endtask
	task sw;
		begin
			cyc(1);
			software_trigger = 1'b1;
			cyc(1);
			software_trigger = 1'b0;
		end
	endtask
	// ----
	// scenarios
	// ----
	task t_soft;
		begin
			trigger_mode_on = 1'b1;
			cmd(0);
			chk(waiting_for_trigger, 1, "wait");
			sw;
			chk(frame_start, 1, "start pulse");
			chk(waiting_for_trigger, 0, "left wait");
			sw; // lands in the exposure and must be dropped
			chk(frame_start, 0, "dropped start");
			timer_active_source = 1'b1; // source not selected
			cyc(20);
			fc++;
			chk(frame_count, fc, "soft frames");
			chk(waiting_for_trigger, 1, "rearm");
			cmd(1);
			timer_active_source = 1'b0;
		end
	endtask
	task t_free(input [31:0] p, m);
		begin
			trigger_mode_on = 1'b0;
			free_run_period = p;
			min_frame_period = m;
			cmd(0);
			chk(acquiring, 1, "acquiring");
			cnt(0, a);
			cnt(1, a);
			cnt(0, b);
			chk(a + b, p > m ? p : m, "free period");
			cmd(1); // stop lands in mid exposure
			fc += 2;
			chk(frame_count, fc, "free frames");
		end
	endtask
	task t_edge;
		integer k;
		begin
			trigger_mode_on = 1'b1;
			cmd(0);
			for (k = 0; k < 3; k++) begin
				cyc(1);
				trigger_source = k == 2 ? `ESTC_SRC_LINE : `ESTC_SRC_LINK;
				edge_select = k != 1; // set after the source
				src.pulse(k != 2, k == 1, 200);
				fc++;
				chk(frame_count, fc, "edge frames");
			end
			cmd(1);
		end
	endtask
	task pw(input [2:0] s, input reg t, input [31:0] lo, hi);
		integer n;
		begin
			cyc(1);
			trigger_source = s;
			timer_edge_activation = t;
			fork
				begin
					cnt(0, n);
					cnt(1, n);
				end
				if (s == `ESTC_SRC_LINE) src.pulse(0, 0, 100);
				else begin
					cyc(2);
					{user_output_source, timer_active_source} = s == `ESTC_SRC_TIMER ? 2'b01 : 2'b10;
					cyc(10);
					{user_output_source, timer_active_source} = 2'b00;
					cyc(10);
				end
			join
			chk(n >= lo && n <= hi, 1, "pulse width");
		end
	endtask
	task t_pulse;
		begin
			exposure_mode = `ESTC_EXP_PULSE;
			edge_select = `ESTC_EDGE_RISING;
			cmd(0);
			pw(`ESTC_SRC_LINE, 0, 9, 11);
			pw(`ESTC_SRC_USER_OUT, 0, 9, 11);
			pw(`ESTC_SRC_TIMER, 1, 6, 6);
			pw(`ESTC_SRC_TIMER, 0, 9, 11);
			cmd(1);
		end
	endtask
	task end_sim;
		begin
			if (n_mismatch == 0 && checks_done > 0) $display("TB: PASS");
			else $display("TB: FAIL");
			$finish;
		end
	endtask
	// ----
	// main sequence and watchdog
	// ----
	initial begin
		cyc(12);
		rst_n = 1'b1;
		chk(frame_count, fc, "reset count");
		t_soft;
		t_free(32'h14, 32'hA);
		t_free(32'h5, 32'h1E);
		t_edge;
		t_pulse;
		end_sim;
	end
	// a hang costs a mismatch; the run needs well under this span
	initial begin
		#200000;
		n_mismatch++;
		end_sim;
	end
endmodule
